// [rtl/arltim_consts.vh]
`ifndef ARLTIM_CONSTS_VH
`define ARLTIM_CONSTS_VH

// count clock prescaler ratios and counter width
`define ARLTIM_DIV_SYS      4'hC
`define ARLTIM_DIV_EXT      4'h8
`define ARLTIM_PRE_W        4
// byte and word values
`define ARLTIM_BYTE_ZERO    8'h00
`define ARLTIM_BYTE_ONES    8'hFF
`define ARLTIM_WORD_ZERO    16'h0000
`define ARLTIM_WORD_ONES    16'hFFFF
// control register bit positions and reset value
`define ARLTIM_CTL_HOVF     7
`define ARLTIM_CTL_LOVF     6
`define ARLTIM_CTL_LIEN     5
`define ARLTIM_CTL_CAPEN    4
`define ARLTIM_CTL_SPLIT    3
`define ARLTIM_CTL_RUN      2
`define ARLTIM_CTL_EXTSEL   0
`define ARLTIM_CTL_RST      8'h00

`endif

// [rtl/arltim_prescale.v]
`timescale 1ns/1ps
`include "arltim_consts.vh"

// free-running divider giving one-cycle enables; the external source is
// synchronised first so the whole timer stays on the system clock
module arltim_prescale (
  input  wire i_clk_sys,
  input  wire i_rst_n,
  input  wire i_ext_osc,
  output reg  o_sys_div_en,
  output reg  o_ext_div_en
);

  reg                     ext_meta_q;
  reg                     ext_sync_q;
  reg                     ext_prev_q;
  reg [`ARLTIM_PRE_W-1:0] sys_cnt_q;
  reg [`ARLTIM_PRE_W-1:0] ext_cnt_q;

  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ext_meta_q   <= 1'b0;
      ext_sync_q   <= 1'b0;
      ext_prev_q   <= 1'b0;
      sys_cnt_q    <= {`ARLTIM_PRE_W{1'b0}};
      ext_cnt_q    <= {`ARLTIM_PRE_W{1'b0}};
      o_sys_div_en <= 1'b0;
      o_ext_div_en <= 1'b0;
    end else begin
      ext_meta_q   <= i_ext_osc;
      ext_sync_q   <= ext_meta_q;
      ext_prev_q   <= ext_sync_q;
      o_sys_div_en <= 1'b0;
      o_ext_div_en <= 1'b0;
      if (sys_cnt_q == `ARLTIM_DIV_SYS - 4'h1) begin
        sys_cnt_q    <= {`ARLTIM_PRE_W{1'b0}};
        o_sys_div_en <= 1'b1;
      end else begin
        sys_cnt_q <= sys_cnt_q + 4'h1;
      end
      // count rising edges of the synchronised external clock
      if (ext_sync_q && !ext_prev_q) begin
        if (ext_cnt_q == `ARLTIM_DIV_EXT - 4'h1) begin
          ext_cnt_q    <= {`ARLTIM_PRE_W{1'b0}};
          o_ext_div_en <= 1'b1;
        end else begin
          ext_cnt_q <= ext_cnt_q + 4'h1;
        end
      end
    end
  end

endmodule

// [rtl/arltim_top.v]
// How it works
// - sixteen-bit count from two writable bytes
// - split bit picks 16-bit or dual 8-bit
// - system_clock, system_clock/12, synchronised external/8 clocks
// - 16-bit rollover reloads and sets high flag
// - timer irq on every 16-bit rollover
// - low-byte rollover irq when low enable set
// - split halves reload from own reload bytes
// - split: run gates high half only
// - per-half fast select, one shared external select
// - split: each half sets its own flag
// - split irq: high, or either with enable
// - flags clear only by software write
// - oscillator falling edge captures count, sets flag
// - capture count clock from low-half select
// - 16-bit count and split high half advance only while run set
`timescale 1ns/1ps
`include "arltim_consts.vh"

module arltim_top (
  input  wire       i_clk_sys,
  input  wire       i_rst_n,
  input  wire       i_ext_osc,
  input  wire       i_lfo,
  input  wire       i_ctl_wr,
  input  wire [7:0] i_ctl_wdata,
  input  wire       i_cnt_lo_wr,
  input  wire       i_cnt_hi_wr,
  input  wire       i_rld_lo_wr,
  input  wire       i_rld_hi_wr,
  input  wire [7:0] i_wdata,
  input  wire       i_high_half_fast_clock_select,
  input  wire       i_low_half_fast_clock_select,
  input  wire       i_timer_irq_enable,
  output reg  [7:0] o_timer_control_register,
  output reg  [7:0] o_count_low_byte,
  output reg  [7:0] o_count_high_byte,
  output reg  [7:0] o_reload_low_byte,
  output reg  [7:0] o_reload_high_byte,
  output reg        o_irq
);

  wire       sys_div_en;
  wire       ext_div_en;
  reg        lfo_meta_q;
  reg        lfo_sync_q;
  reg        lfo_prev_q;
  reg        hovf_q;
  reg        lovf_q;
  reg        lien_q;
  reg        capen_q;
  reg        split_q;
  reg        run_q;
  reg        extsel_q;
  reg        lo_tick;
  reg        hi_tick;
  reg        lo_roll;
  reg        hi_roll;
  reg        cap_stb;
  reg  [7:0] cnt_lo_d;
  reg  [7:0] cnt_hi_d;
  reg  [7:0] rld_lo_d;
  reg  [7:0] rld_hi_d;
  reg        hovf_set;
  reg        lovf_set;
  reg        hovf_d;
  reg        lovf_d;

  // per-half clock choice: fast bit wins, else external/8 or system_clock/12
  function sel_tick;
    input fast;
    input ext;
    input div12;
    input div8;
    begin
      sel_tick = fast ? 1'b1 : (ext ? div8 : div12);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  arltim_prescale u_pre (
    .i_clk_sys    (i_clk_sys),
    .i_rst_n      (i_rst_n),
    .i_ext_osc    (i_ext_osc),
    .o_sys_div_en (sys_div_en),
    .o_ext_div_en (ext_div_en)
  );

  ////////////////////////////////////////////////////////////////////////
  always @* begin
    cap_stb  = capen_q && lfo_prev_q && !lfo_sync_q;
    lo_tick  = sel_tick(i_low_half_fast_clock_select, extsel_q,
                        sys_div_en, ext_div_en);
    hi_tick  = sel_tick(i_high_half_fast_clock_select, extsel_q,
                        sys_div_en, ext_div_en);
    cnt_lo_d = o_count_low_byte;
    cnt_hi_d = o_count_high_byte;
    rld_lo_d = o_reload_low_byte;
    rld_hi_d = o_reload_high_byte;
    lo_roll  = 1'b0;
    hi_roll  = 1'b0;
    if (split_q) begin
      // low half runs regardless of run bit
      if (lo_tick) begin
        lo_roll  = (o_count_low_byte == `ARLTIM_BYTE_ONES);
        cnt_lo_d = lo_roll ? o_reload_low_byte : o_count_low_byte + 8'h01;
      end
      if (hi_tick && run_q) begin
        hi_roll  = (o_count_high_byte == `ARLTIM_BYTE_ONES);
        cnt_hi_d = hi_roll ? o_reload_high_byte : o_count_high_byte + 8'h01;
      end
    end else if (lo_tick && run_q) begin
      // 16-bit count uses the low-half clock selection
      lo_roll = (o_count_low_byte == `ARLTIM_BYTE_ONES);
      hi_roll = ({o_count_high_byte, o_count_low_byte} == `ARLTIM_WORD_ONES);
      if (hi_roll) begin
        cnt_lo_d = o_reload_low_byte;
        cnt_hi_d = o_reload_high_byte;
      end else begin
        {cnt_hi_d, cnt_lo_d} = {o_count_high_byte, o_count_low_byte} + 16'h0001;
      end
    end
    // software byte writes override the count step
    if (i_cnt_lo_wr) cnt_lo_d = i_wdata;
    if (i_cnt_hi_wr) cnt_hi_d = i_wdata;
    if (i_rld_lo_wr) rld_lo_d = i_wdata;
    if (i_rld_hi_wr) rld_hi_d = i_wdata;
    if (cap_stb) begin
      rld_lo_d = o_count_low_byte;
      rld_hi_d = o_count_high_byte;
    end
    hovf_set = hi_roll || cap_stb;
    lovf_set = lo_roll;
    // a hardware set wins over a software clear in the same cycle
    hovf_d = (i_ctl_wr ? i_ctl_wdata[`ARLTIM_CTL_HOVF] : hovf_q) | hovf_set;
    lovf_d = (i_ctl_wr ? i_ctl_wdata[`ARLTIM_CTL_LOVF] : lovf_q) | lovf_set;
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      lfo_meta_q               <= 1'b0;
      lfo_sync_q               <= 1'b0;
      lfo_prev_q               <= 1'b0;
      hovf_q                   <= 1'b0;
      lovf_q                   <= 1'b0;
      lien_q                   <= 1'b0;
      capen_q                  <= 1'b0;
      split_q                  <= 1'b0;
      run_q                    <= 1'b0;
      extsel_q                 <= 1'b0;
      o_timer_control_register <= `ARLTIM_CTL_RST;
      o_count_low_byte         <= `ARLTIM_BYTE_ZERO;
      o_count_high_byte        <= `ARLTIM_BYTE_ZERO;
      o_reload_low_byte        <= `ARLTIM_BYTE_ZERO;
      o_reload_high_byte       <= `ARLTIM_BYTE_ZERO;
      o_irq                    <= 1'b0;
    end else begin
      lfo_meta_q         <= i_lfo;
      lfo_sync_q         <= lfo_meta_q;
      lfo_prev_q         <= lfo_sync_q;
      hovf_q             <= hovf_d;
      lovf_q             <= lovf_d;
      o_count_low_byte   <= cnt_lo_d;
      o_count_high_byte  <= cnt_hi_d;
      o_reload_low_byte  <= rld_lo_d;
      o_reload_high_byte <= rld_hi_d;
      if (i_ctl_wr) begin
        lien_q   <= i_ctl_wdata[`ARLTIM_CTL_LIEN];
        capen_q  <= i_ctl_wdata[`ARLTIM_CTL_CAPEN];
        split_q  <= i_ctl_wdata[`ARLTIM_CTL_SPLIT];
        run_q    <= i_ctl_wdata[`ARLTIM_CTL_RUN];
        extsel_q <= i_ctl_wdata[`ARLTIM_CTL_EXTSEL];
      end
      // readback mirrors the next state; unused bit reads zero
      o_timer_control_register <= {hovf_d, lovf_d,
        i_ctl_wr ? i_ctl_wdata[`ARLTIM_CTL_LIEN:`ARLTIM_CTL_RUN]
                 : {lien_q, capen_q, split_q, run_q},
        1'b0,
        i_ctl_wr ? i_ctl_wdata[`ARLTIM_CTL_EXTSEL] : extsel_q};
      // level request while any enabled flag is pending
      o_irq <= i_timer_irq_enable &&
               (hovf_d || (lovf_d && (i_ctl_wr ? i_ctl_wdata[`ARLTIM_CTL_LIEN]
                                                : lien_q)));
    end
  end

endmodule

// [tb/arltim_assertions.sv]
`timescale 1ns/1ps
module arltim_chk (
  input wire       i_clk_sys,
  input wire       i_rst_n,
  input wire       i_lfo,
  input wire       i_ctl_wr,
  input wire       i_cnt_lo_wr,
  input wire       i_cnt_hi_wr,
  input wire       i_rld_lo_wr,
  input wire       i_rld_hi_wr,
  input wire       i_low_half_fast_clock_select,
  input wire       i_timer_irq_enable,
  input wire [7:0] o_timer_control_register,
  input wire [7:0] o_count_low_byte,
  input wire [7:0] o_count_high_byte,
  input wire [7:0] o_reload_low_byte,
  input wire [7:0] o_reload_high_byte,
  input wire       o_irq
);
  wire [7:0]  ctl = o_timer_control_register;
  wire [15:0] cnt = {o_count_high_byte, o_count_low_byte};
  wire [15:0] rld = {o_reload_high_byte, o_reload_low_byte};
  wire        en  = i_timer_irq_enable;
  wire        fl  = i_low_half_fast_clock_select;
  // any write in the cycle may override the hardware update, so it is excluded
  wire        nw  = !(i_ctl_wr | i_cnt_lo_wr | i_cnt_hi_wr | i_rld_lo_wr | i_rld_hi_wr);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_hold; !ctl[2] && !ctl[3] && nw |=> $stable(cnt); endproperty
  a_hold: assert property (p_hold) else $error("count moved while stopped");
  property p_stk_h; ctl[7] && !i_ctl_wr |=> ctl[7]; endproperty
  a_stk_h: assert property (p_stk_h) else $error("high flag self-cleared");
  property p_stk_l; ctl[6] && !i_ctl_wr |=> ctl[6]; endproperty
  a_stk_l: assert property (p_stk_l) else $error("low flag self-cleared");
  property p_roll16;
    !ctl[3] && ctl[2] && fl && nw && cnt == 16'hFFFF |=> cnt == $past(rld) && ctl[7];
  endproperty
  a_roll16: assert property (p_roll16) else $error("bad 16-bit reload");
  property p_sp_lo;
    ctl[3] && fl && nw && o_count_low_byte == 8'hFF
      |=> o_count_low_byte == $past(o_reload_low_byte) && ctl[6];
  endproperty
  a_sp_lo: assert property (p_sp_lo) else $error("bad low half reload");
  property p_sp_run;
    ctl[3] && fl && nw && o_count_low_byte != 8'hFF
      |=> o_count_low_byte == $past(o_count_low_byte) + 8'h01;
  endproperty
  a_sp_run: assert property (p_sp_run) else $error("low half not counting");
  property p_irq_on; en && $past(en) && ctl[7] |-> o_irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_irq_off; !en && !$past(en) |-> !o_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_cap; ctl[4] && $fell(i_lfo) |-> ##[2:6] ctl[7]; endproperty
  a_cap: assert property (p_cap) else $error("capture flag missing");
  c_irq: cover property (ctl[7] && o_irq);
  c_split: cover property (ctl[3] && ctl[6]);
  c_cap: cover property (ctl[4] && ctl[7]);
endmodule
bind arltim_top arltim_chk u_chk (.*);

// [tb/arltim_top_tb.sv]
`timescale 1ns/1ps
module arltim_top_tb;
  reg        i_clk_sys = 1'b0;
  reg        i_rst_n = 1'b0;
  reg        i_ext_osc = 1'b0;
  reg        i_lfo = 1'b1;
  reg        i_ctl_wr = 1'b0;
  reg  [7:0] i_ctl_wdata = 8'h00;
  reg        i_cnt_lo_wr = 1'b0;
  reg        i_cnt_hi_wr = 1'b0;
  reg        i_rld_lo_wr = 1'b0;
  reg        i_rld_hi_wr = 1'b0;
  reg  [7:0] i_wdata = 8'h00;
  reg        i_high_half_fast_clock_select = 1'b1;
  reg        i_low_half_fast_clock_select = 1'b1;
  reg        i_timer_irq_enable = 1'b1;
  wire [7:0] o_timer_control_register;
  wire [7:0] o_count_low_byte;
  wire [7:0] o_count_high_byte;
  wire [7:0] o_reload_low_byte;
  wire [7:0] o_reload_high_byte;
  wire       o_irq;
  integer    err_count = 0;
  integer    n_checks = 0;
  integer    k;
  integer    m;
  reg [15:0] sv;
  arltim_top dut (.*);
  always #10 i_clk_sys = ~i_clk_sys;
  // external source rising edge every 5 cycles, so one /8 tick per 40 cycles
  // offset by a quarter period so the pin never moves on a sampling edge
  initial begin
    #5;
    forever #50 i_ext_osc = ~i_ext_osc;
  end
  ////////////////////////////////////////////////////////////////////////////
  task wrap_up;
    begin
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [23:0] got, input [23:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // s: 0 control, 1 count low, 2 count high, 3 reload low, 4 reload high
  task wr(input [2:0] s, input [7:0] d);
    begin
      @(negedge i_clk_sys);
      i_ctl_wdata = d;
      i_wdata = d;
      {i_rld_hi_wr, i_rld_lo_wr, i_cnt_hi_wr, i_cnt_lo_wr, i_ctl_wr} = 5'h01 << s;
      @(negedge i_clk_sys);
      {i_rld_hi_wr, i_rld_lo_wr, i_cnt_hi_wr, i_cnt_lo_wr, i_ctl_wr} = 5'h00;
    end
  endtask
  task wait_bit(input [2:0] b);
    begin
      k = 0;
      while (o_timer_control_register[b] !== 1'b1 && k < 2000) begin
        @(negedge i_clk_sys);
        k = k + 1;
      end
      if (k == 2000) begin
        chk(24'h0, 24'h1);
        wrap_up;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_rw;
    begin
      wr(1, 8'hA5);
      wr(2, 8'h5A);
      wr(3, 8'hC3);
      wr(4, 8'h3C);
      wr(0, 8'h22);
      chk({o_count_high_byte, o_count_low_byte}, 16'h5AA5);
      chk({o_reload_high_byte, o_reload_low_byte}, 16'h3CC3);
      chk(o_timer_control_register, 8'h20);
      wr(0, 8'h00);
    end
  endtask
  task t_roll;
    begin
      wr(3, 8'h34);
      wr(4, 8'h12);
      wr(1, 8'hFE);
      wr(2, 8'hFF);
      wr(0, 8'h04);
      wait_bit(7);
      chk({o_count_high_byte, o_count_low_byte}, 16'h1234);
      chk({o_irq, o_timer_control_register[7:6]}, 3'h7);
      wr(0, 8'h00);
      chk({o_irq, o_timer_control_register}, 9'h000);
      sv = {o_count_high_byte, o_count_low_byte};
      repeat (5) @(negedge i_clk_sys);
      chk({o_count_high_byte, o_count_low_byte}, sv);
    end
  endtask
  // flag pending with the system enable off must not request
  task t_irq_off;
    begin
      i_timer_irq_enable = 1'b0;
      wr(0, 8'h80);
      repeat (2) @(negedge i_clk_sys);
      chk({o_irq, o_timer_control_register[7]}, 2'h1);
      i_timer_irq_enable = 1'b1;
      @(negedge i_clk_sys);
      chk(o_irq, 1'b1);
      wr(0, 8'h00);
    end
  endtask
  task t_low;
    for (m = 0; m < 2; m = m + 1) begin
      wr(1, 8'hFE);
      wr(2, 8'h00);
      wr(0, m ? 8'h24 : 8'h04);
      wait_bit(6);
      chk({o_irq, o_timer_control_register[7]}, {m[0], 1'b0});
      wr(0, 8'h00);
    end
  endtask
  task t_split;
    begin
      wr(3, 8'hF0);
      wr(4, 8'hA0);
      wr(1, 8'hFE);
      wr(2, 8'hFF);
      wr(0, 8'h08);
      wait_bit(6);
      chk({o_count_high_byte, o_count_low_byte, o_irq}, 17'h1FFE0);
      wr(0, 8'h0C);
      wait_bit(7);
      chk({o_count_high_byte, o_irq}, 9'h141);
      wr(0, 8'h00);
    end
  endtask
  task t_div;
    for (m = 0; m < 2; m = m + 1) begin
      i_low_half_fast_clock_select = 1'b0;
      i_high_half_fast_clock_select = 1'b0;
      wr(1, 8'h00);
      wr(2, 8'h00);
      wr(0, m ? 8'h05 : 8'h04);
      repeat (m ? 400 : 120) @(negedge i_clk_sys);
      wr(0, 8'h00);
      chk(o_count_low_byte >= 8'h08 && o_count_low_byte <= 8'h0C, 1'b1);
      i_low_half_fast_clock_select = 1'b1;
      i_high_half_fast_clock_select = 1'b1;
    end
  endtask
  task t_cap;
    begin
      wr(1, 8'h00);
      wr(2, 8'h00);
      wr(0, 8'h14);
      repeat (20) @(negedge i_clk_sys);
      i_lfo = 1'b0;
      sv = {o_count_high_byte, o_count_low_byte};
      wait_bit(7);
      sv = {o_reload_high_byte, o_reload_low_byte} - sv;
      chk(sv >= 16'h0001 && sv <= 16'h0006, 1'b1);
      i_lfo = 1'b1;
      wr(0, 8'h00);
    end
  endtask
  initial begin
    repeat (6) @(negedge i_clk_sys);
    chk({o_timer_control_register, o_count_low_byte, o_irq}, 17'h0);
    i_rst_n = 1'b1;
    t_rw;
    t_roll;
    t_irq_off;
    t_low;
    t_split;
    t_div;
    t_cap;
    wrap_up;
  end
endmodule
